/* verilog/rf_timer_params.svh */
// Register offsets, field positions and timing figures of the reader timer bank.
`ifndef RF_TIMER_PARAMS_SVH
`define RF_TIMER_PARAMS_SVH

// Register indices; the byte address is four times the index.
`define IDX_RUN_CONTROL     6'h0e
`define IDX_A_CONTROL       6'h0f
`define IDX_A_RELOAD_HIGH   6'h10
`define IDX_A_RELOAD_LOW    6'h11
`define IDX_A_COUNT_HIGH    6'h12
`define IDX_A_COUNT_LOW     6'h13
`define IDX_B_CONTROL       6'h14
`define IDX_IRQ_STATUS      6'h20
`define IDX_IRQ_CLEAR       6'h21
`define IDX_IRQ_ENABLE      6'h22

// Timer control register fields.
`define CTL_STOP_RX         7
`define CTL_START_HI        5
`define CTL_START_LO        4
`define CTL_RELOAD          3
`define CTL_CLK_HI          1
`define CTL_CLK_LO          0
`define CTL_WRITE_MASK      8'hbb

// Auto-start and clock-select codes.
`define START_NONE          2'h0
`define START_TX_END        2'h1
`define START_TRIM_HOLD     2'h2
`define START_TRIM_WRAP     2'h3
`define CLK_FAST            2'h0
`define CLK_SLOW            2'h1
`define CLK_TIMER_C         2'h2
`define CLK_TIMER_B         2'h3

// Interrupt status bits.
`define IRQ_UNDERFLOW       0
`define IRQ_RX_STOP         1

// Count clock rates in Hz against the 200 MHz system clock.
`define SYS_CLK_HZ          29'h0bebc200
`define FAST_CLK_HZ         29'h00cee8c0
`define SLOW_CLK_HZ         29'h00033ba3

`endif

/* verilog/rf_timer_pkg.sv */
// Shared types of the reader timer bank.
package rf_timer_pkg;
  typedef logic [7:0]  reg_byte_t;
  typedef logic [15:0] count_t;
  typedef logic [28:0] phase_t;
endpackage

/* verilog/rf_reader_timer_bank.sv */
// Timer bank of the reader transceiver: run control, first timer and Wishbone registers.
//
// Functional notes
// R01: A run-control write changes a running bit only where its low-nibble mask bit is one.
// R02: Writing ff sets all four running bits; writing f0 changes none.
// R03: Bits 7 to 4 report whether the fourth to first timer counts.
// R04: A masked running-bit write starts or stops that timer at once.
// R05: With stop-on-receive set, the timer halts after four received bits.
// R06: Stop-on-receive is ignored while auto-start selects oscillator trimming.
// R07: Auto-start 00 never starts; 01 starts at the end of transmission.
// R08: Auto-start 10 and 11 trim on slow oscillator edges, without and with underflow.
// R09: With reload-on-zero set, the timer reloads and keeps counting at zero.
// R10: With reload-on-zero clear, the timer stops at zero and clears running.
// R11: Each underflow sets the timer underflow flag.
// R12: Clock select 00 counts at 13.56 MHz, 01 at 211.875 kHz.
// R13: Clock select 10 counts third timer underflows, 11 second timer underflows.
// R14: Each start loads the counter from the high and low reload bytes.
// R15: Reload writes do not disturb a running count; they act at next start.
// R16: Software must not read the count bytes during a reception.
// R17: Control holds stop-on-receive 7, auto-start 5:4, reload 3, clock 1:0.
// R18: The second timer has a control register of the same layout.
// R19: A running timer decrements per tick; underflow is a tick at zero.
`include "rf_timer_params.svh"

module rf_reader_timer_bank (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq,
  input  wire logic        tx_end,
  input  wire logic        rx_first_nibble,
  input  wire logic        slow_oscillator,
  input  wire logic        timer_b_underflow,
  input  wire logic        timer_c_underflow,
  output logic             timer_b_active,
  output logic             timer_c_active,
  output logic             timer_d_active,
  output logic      [7:0]  timer_b_control
);

  // Fractional rate step: adds the rate and wraps at the system rate, carry on top.
  function automatic rf_timer_pkg::phase_t phase_step(input rf_timer_pkg::phase_t acc,
                                                      input rf_timer_pkg::phase_t rate);
    rf_timer_pkg::phase_t sum;
    sum = acc + rate;
    if (sum >= `SYS_CLK_HZ) begin
      phase_step = sum - `SYS_CLK_HZ;
    end else begin
      phase_step = sum;
    end
  endfunction

  rf_timer_pkg::reg_byte_t timer_a_control;
  rf_timer_pkg::reg_byte_t timer_a_reload_high;
  rf_timer_pkg::reg_byte_t timer_a_reload_low;
  rf_timer_pkg::count_t    timer_a_count;
  rf_timer_pkg::reg_byte_t irq_status;
  rf_timer_pkg::reg_byte_t irq_enable;
  rf_timer_pkg::phase_t    fast_phase;
  rf_timer_pkg::phase_t    slow_phase;
  logic                    timer_a_active;
  logic                    fast_tick;
  logic                    slow_tick;
  logic                    slow_osc_prev;
  logic                    bus_req;
  logic                    bus_wr;
  logic [5:0]              bus_idx;
  rf_timer_pkg::reg_byte_t wr_byte;
  logic                    wr_run;
  rf_timer_pkg::count_t    reload_word;
  logic [1:0]              auto_start_select;
  logic [1:0]              count_clock_select;
  logic                    stop_on_receive;
  logic                    reload_on_zero;
  logic                    trim_mode;
  logic                    osc_rise;
  logic                    tick_a;
  logic                    start_a;
  logic                    stop_a;
  logic                    rx_stop_a;
  logic                    at_zero;
  logic                    underflow_a;
  rf_timer_pkg::reg_byte_t next_rd;

  assign bus_req            = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr             = bus_req & wb_we_i & wb_sel_i[0];
  assign bus_idx            = wb_adr_i[7:2];
  assign wr_byte            = wb_dat_i[7:0];
  assign wr_run             = bus_wr && bus_idx == `IDX_RUN_CONTROL;
  assign reload_word        = {timer_a_reload_high, timer_a_reload_low};
  assign auto_start_select  = timer_a_control[`CTL_START_HI:`CTL_START_LO];
  assign count_clock_select = timer_a_control[`CTL_CLK_HI:`CTL_CLK_LO];
  assign stop_on_receive    = timer_a_control[`CTL_STOP_RX];
  assign reload_on_zero     = timer_a_control[`CTL_RELOAD];
  assign trim_mode          = auto_start_select[1];
  assign osc_rise           = slow_oscillator & ~slow_osc_prev;
  assign at_zero            = timer_a_count == 16'h0000;

  // Both count clocks come from phase accumulators, so their mean rate is exact
  // although single tick spacings jitter by one system cycle.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fast_phase <= 29'h00000000;
      slow_phase <= 29'h00000000;
      fast_tick  <= 1'b0;
      slow_tick  <= 1'b0;
    end else begin
      fast_phase <= phase_step(fast_phase, `FAST_CLK_HZ);
      slow_phase <= phase_step(slow_phase, `SLOW_CLK_HZ);
      fast_tick  <= (fast_phase + `FAST_CLK_HZ) >= `SYS_CLK_HZ; // [R12]
      slow_tick  <= (slow_phase + `SLOW_CLK_HZ) >= `SYS_CLK_HZ; // [R12]
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      slow_osc_prev <= 1'b0;
    end else begin
      slow_osc_prev <= slow_oscillator;
    end
  end

  always_comb begin
    unique case (count_clock_select)
      `CLK_FAST:    tick_a = fast_tick;          // [R12]
      `CLK_SLOW:    tick_a = slow_tick;          // [R12]
      `CLK_TIMER_C: tick_a = timer_c_underflow;  // [R13]
      `CLK_TIMER_B: tick_a = timer_b_underflow;  // [R13]
    endcase
  end

  // A masked software write outranks every hardware start or stop in the same cycle.
  always_comb begin
    rx_stop_a = timer_a_active & stop_on_receive & ~trim_mode & rx_first_nibble; // [R05] [R06]
    if (wr_run && wr_byte[0]) begin
      start_a = wr_byte[4];   // [R01] [R04]
      stop_a  = ~wr_byte[4];  // [R04]
    end else begin
      start_a = ~timer_a_active & ((auto_start_select == `START_TX_END & tx_end) // [R07]
                                   | (trim_mode & osc_rise));                   // [R08]
      stop_a  = rx_stop_a | (timer_a_active & trim_mode & osc_rise);            // [R05] [R08]
    end
  end

  // In the hold trimming mode the count rests at zero instead of underflowing.
  assign underflow_a = timer_a_active & tick_a & at_zero & ~start_a & ~stop_a
                       & (auto_start_select != `START_TRIM_HOLD); // [R08] [R19]

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      timer_a_active <= 1'b0;
    end else if (start_a) begin
      timer_a_active <= 1'b1;  // [R04]
    end else if (stop_a) begin
      timer_a_active <= 1'b0;  // [R04] [R05]
    end else if (underflow_a && !reload_on_zero) begin
      timer_a_active <= 1'b0;  // [R10]
    end
  end

  // Reload bytes are only sampled here, so rewriting them mid-count is harmless.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      timer_a_count <= 16'h0000;
    end else if (start_a) begin
      timer_a_count <= reload_word;  // [R14] [R15]
    end else if (timer_a_active && !stop_a && tick_a) begin
      if (!at_zero) begin
        timer_a_count <= timer_a_count - 16'h0001;  // [R19]
      end else if (underflow_a && reload_on_zero) begin
        timer_a_count <= reload_word;  // [R09]
      end
    end
  end

  // The other timers keep their counters elsewhere; only their run bits and the second timer's control register live here.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      timer_b_active <= 1'b0;
      timer_c_active <= 1'b0;
      timer_d_active <= 1'b0;
    end else if (wr_run) begin
      if (wr_byte[1]) begin
        timer_b_active <= wr_byte[5];  // [R01] [R02]
      end
      if (wr_byte[2]) begin
        timer_c_active <= wr_byte[6];  // [R01] [R02]
      end
      if (wr_byte[3]) begin
        timer_d_active <= wr_byte[7];  // [R01] [R02]
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      timer_a_control     <= 8'h00;
      timer_b_control     <= 8'h00;
      timer_a_reload_high <= 8'h00;
      timer_a_reload_low  <= 8'h00;
      irq_enable          <= 8'h00;
    end else if (bus_wr) begin
      case (bus_idx)
        `IDX_A_CONTROL:     timer_a_control     <= wr_byte & `CTL_WRITE_MASK; // [R17]
        `IDX_B_CONTROL:     timer_b_control     <= wr_byte & `CTL_WRITE_MASK; // [R18]
        `IDX_A_RELOAD_HIGH: timer_a_reload_high <= wr_byte;                   // [R15]
        `IDX_A_RELOAD_LOW:  timer_a_reload_low  <= wr_byte;                   // [R15]
        `IDX_IRQ_ENABLE:    irq_enable          <= wr_byte;
        default: ;
      endcase
    end
  end

  // A hardware event in the same cycle as a software clear stays set.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_status <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (i == `IRQ_UNDERFLOW && underflow_a) begin
          irq_status[i] <= 1'b1;  // [R11]
        end else if (i == `IRQ_RX_STOP && rx_stop_a && !(wr_run && wr_byte[0])) begin
          irq_status[i] <= 1'b1;  // [R05]
        end else if (bus_wr && bus_idx == `IDX_IRQ_CLEAR && wr_byte[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

  always_comb begin
    case (bus_idx)
      `IDX_RUN_CONTROL:   next_rd = {timer_d_active, timer_c_active, timer_b_active, timer_a_active, 4'h0}; // [R03]
      `IDX_A_CONTROL:     next_rd = timer_a_control;
      `IDX_A_RELOAD_HIGH: next_rd = timer_a_reload_high;
      `IDX_A_RELOAD_LOW:  next_rd = timer_a_reload_low;
      `IDX_A_COUNT_HIGH:  next_rd = timer_a_count[15:8];
      `IDX_A_COUNT_LOW:   next_rd = timer_a_count[7:0];
      `IDX_B_CONTROL:     next_rd = timer_b_control;
      `IDX_IRQ_STATUS:    next_rd = irq_status;
      `IDX_IRQ_ENABLE:    next_rd = irq_enable;
      default:            next_rd = 8'h00;
    endcase
  end

  // Every access, mapped or not, is answered one cycle after the strobe.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req) begin
        wb_dat_o <= wb_we_i ? 32'h00000000 : {24'h000000, next_rd};
      end
    end
  end

  default clocking dflt_cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  sequence seq_sw_start;
    wr_run && wr_byte[0] && wr_byte[4];
  endsequence

  sequence seq_loaded(rf_timer_pkg::count_t v);
    timer_a_active && timer_a_count == v;
  endsequence

  chk_mask_keep: assert property (wr_run && !wr_byte[1] |=> timer_b_active == $past(timer_b_active)) // [R01]
    else $error("masked run bit changed");
  chk_write_all: assert property (wr_run && wr_byte == 8'hff |=> timer_a_active && timer_b_active // [R02]
                                  && timer_c_active && timer_d_active)
    else $error("all-ones write did not start all timers");
  chk_mask_none: assert property (wr_run && wr_byte[3:0] == 4'h0 // [R02]
                                  |=> {timer_d_active, timer_c_active, timer_b_active}
                                      == $past({timer_d_active, timer_c_active, timer_b_active}))
    else $error("unmasked write changed a run bit");
  chk_run_readback: assert property (wb_ack_o && !wb_we_i && bus_idx == `IDX_RUN_CONTROL // [R03]
                                     |-> wb_dat_o[7:4] == $past({timer_d_active, timer_c_active,
                                                                 timer_b_active, timer_a_active}))
    else $error("run readback wrong");
  chk_sw_start: assert property (seq_sw_start |=> seq_loaded($past(reload_word))) // [R04]
    else $error("software start did not load reload word");
  chk_sw_stop: assert property (wr_run && wr_byte[0] && !wr_byte[4] |=> !timer_a_active) // [R04]
    else $error("software stop missed");
  chk_rx_halt: assert property (rx_stop_a && !wr_run |=> !timer_a_active) // [R05]
    else $error("receive stop missed");
  chk_rx_flag: assert property (rx_stop_a && !(wr_run && wr_byte[0]) // [R05]
                                |=> irq_status[`IRQ_RX_STOP])
    else $error("receive stop flag not set");
  chk_trim_ignore: assert property (timer_a_active && trim_mode && !osc_rise && !wr_run // [R06]
                                    && !underflow_a |=> timer_a_active)
    else $error("trimming timer stopped early");
  chk_tx_start: assert property (!timer_a_active && auto_start_select == `START_TX_END && tx_end // [R07]
                                 && !wr_run |=> timer_a_active)
    else $error("auto start missed");
  chk_no_auto: assert property (!timer_a_active && auto_start_select == `START_NONE && !wr_run // [R07]
                                |=> !timer_a_active)
    else $error("timer started without a start source");
  chk_trim_rest: assert property (timer_a_active && auto_start_select == `START_TRIM_HOLD && at_zero // [R08]
                                  && !start_a |=> timer_a_count == 16'h0000)
    else $error("hold trimming count left zero");
  chk_reload_run: assert property (underflow_a && reload_on_zero |=> seq_loaded($past(reload_word))) // [R09]
    else $error("reload on zero failed");
  chk_one_shot: assert property (underflow_a && !reload_on_zero |=> !timer_a_active) // [R10]
    else $error("one-shot timer kept running");
  chk_flag_set: assert property (underflow_a |=> irq_status[`IRQ_UNDERFLOW]) // [R11]
    else $error("underflow flag not set");
  chk_flag_sticky: assert property (irq_status[`IRQ_UNDERFLOW] && !(bus_wr && bus_idx == `IDX_IRQ_CLEAR // [R11]
                                    && wr_byte[`IRQ_UNDERFLOW]) |=> irq_status[`IRQ_UNDERFLOW])
    else $error("underflow flag lost without clear");
  chk_irq_level: assert property (irq == |$past(irq_status & irq_enable))
    else $error("interrupt level wrong");
  chk_cascade_b: assert property (count_clock_select == `CLK_TIMER_B && timer_a_active // [R13]
                                  && timer_b_underflow && !at_zero && !start_a && !stop_a
                                  |=> timer_a_count == $past(timer_a_count) - 16'h0001)
    else $error("cascade tick not counted");
  chk_decrement: assert property (timer_a_active && tick_a && !at_zero && !start_a && !stop_a // [R19]
                                  |=> timer_a_count == $past(timer_a_count) - 16'h0001)
    else $error("count did not decrement");
  chk_reload_quiet: assert property (timer_a_active && !start_a && !tick_a // [R15]
                                     |=> timer_a_count == $past(timer_a_count))
    else $error("count moved without tick");

endmodule

/* dv/tb_rf_reader_timer_bank.sv */
// Self-checking bench of the reader timer bank, driven over Wishbone.
`include "rf_timer_params.svh"
module tb_rf_reader_timer_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic        timer_b_active, timer_c_active, timer_d_active;
  logic [4:0]  ev;
  logic [7:0]  wb_adr_i, timer_b_control, rnd, run, v;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [15:0] notes[$], rv, bnd;
  int          mismatches, tests_run, cycles;
  logic [5:0]  idx_list [9] = '{6'h0e, 6'h0f, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h20, 6'h22};

  rf_reader_timer_bank u_rf_reader_timer_bank (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .irq(irq),
    .tx_end(ev[3]),
    .rx_first_nibble(ev[2]),
    .slow_oscillator(ev[4]),
    .timer_b_underflow(ev[1]),
    .timer_c_underflow(ev[0]),
    .timer_b_active(timer_b_active),
    .timer_c_active(timer_c_active),
    .timer_d_active(timer_d_active),
    .timer_b_control(timer_b_control)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic report_and_stop;
    if (mismatches == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Each note holds the lowest and highest byte a read may return; write answers must read zero.
  task automatic wb(input logic we, input logic [5:0] idx, input logic [7:0] d, input logic [3:0] sel,
                    input logic [15:0] b);
    notes.push_back(we ? 16'h0000 : b);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'h1};
    wb_sel_i <= sel;
    wb_dat_i <= {rnd, rnd, rnd, d};
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d, 4'hf, 16'h0);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00, 4'hf, {e, e});
  endtask

  // Counts are only read while no reception is under way.
  task automatic rd_count(input logic [15:0] c);
    rd(`IDX_A_COUNT_HIGH, c[15:8]);
    rd(`IDX_A_COUNT_LOW, c[7:0]);
  endtask

  task automatic pulse(input int which, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      ev[which] <= 1'b1;
      @(posedge ref_clk);
      ev <= 5'h00;
    end
  endtask

  task automatic start(input logic [7:0] ctl, input logic [15:0] r);
    wr(`IDX_A_CONTROL, ctl);
    wr(`IDX_A_RELOAD_HIGH, r[15:8]);
    wr(`IDX_A_RELOAD_LOW, r[7:0]);
    wr(`IDX_RUN_CONTROL, 8'h11);
  endtask

  task automatic irq_is(input logic b);
    @(posedge ref_clk);
    check({31'h0, irq}, {31'h0, b});
  endtask

  // Tick phase is free running, so a measured count is allowed two ticks either way.
  task automatic measure(input logic [7:0] clk, input int n, input logic [7:0] t);
    start(clk, 16'hffff);
    repeat (n) @(posedge ref_clk);
    wr(`IDX_RUN_CONTROL, 8'h01);
    rd(`IDX_A_COUNT_HIGH, 8'hff);
    wb(1'b0, `IDX_A_COUNT_LOW, 8'h00, 4'hf, {8'hff - t - 8'h02, 8'hff - t + 8'h02});
  endtask

  always @(posedge ref_clk) begin
    if (wb_ack_o === 1'b1) begin
      bnd = notes.pop_front();
      check({31'h0, wb_dat_o[31:8] === 24'h0 && wb_dat_o[7:0] >= bnd[15:8] && wb_dat_o[7:0] <= bnd[7:0]},
            32'h1);
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      report_and_stop();
    end
  end

  initial begin
    resetn = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, ev} = '0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    rnd = 8'h3a;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    foreach (idx_list[i]) rd(idx_list[i], 8'h00);
    wr(6'h30, 8'hff);
    rd(6'h30, 8'h00);
    repeat (4) begin
      rnd = lfsr(rnd);
      wr(`IDX_A_CONTROL, rnd);
      wb(1'b1, `IDX_A_CONTROL, ~rnd, 4'he, 16'h0);
      rd(`IDX_A_CONTROL, rnd & `CTL_WRITE_MASK);
      wr(`IDX_B_CONTROL, ~rnd);
      rd(`IDX_B_CONTROL, ~rnd & `CTL_WRITE_MASK);
      check({24'h0, timer_b_control}, {24'h0, ~rnd & 8'hbb});
    end
    // The first timer counts only cascade ticks here, so its running bit is stable.
    wr(`IDX_A_CONTROL, 8'h02);
    run = 8'h00;
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      v = (i == 0) ? 8'hff : (i == 1) ? 8'hf0 : rnd;
      wr(`IDX_RUN_CONTROL, v);
      run = (run & ~{v[3:0], 4'h0}) | (v & {v[3:0], 4'h0});
      rd(`IDX_RUN_CONTROL, run);
      @(posedge ref_clk);
      check({29'h0, timer_d_active, timer_c_active, timer_b_active}, {29'h0, run[7:5]});
    end
    wr(`IDX_RUN_CONTROL, 8'h0f);
    rnd = lfsr(rnd);
    rv = {rnd | 8'h01, lfsr(rnd)};
    start(8'h02, rv);
    rd_count(rv);
    pulse(0, 5);
    pulse(1, 3);
    rd_count(rv - 16'h5);
    wr(`IDX_A_CONTROL, 8'h03);
    pulse(0, 2);
    pulse(1, 2);
    rd_count(rv - 16'h7);
    wr(`IDX_A_RELOAD_HIGH, 8'h12);
    wr(`IDX_A_RELOAD_LOW, 8'h34);
    rd_count(rv - 16'h7);
    wr(`IDX_RUN_CONTROL, 8'h11);
    rd_count(16'h1234);
    start(8'h02, 16'h0002);
    pulse(0, 3);
    rd(`IDX_RUN_CONTROL, 8'h00);
    rd(`IDX_IRQ_STATUS, 8'h01);
    irq_is(1'b0);
    wr(`IDX_IRQ_ENABLE, 8'h01);
    irq_is(1'b1);
    wr(`IDX_IRQ_CLEAR, 8'h01);
    rd(`IDX_IRQ_STATUS, 8'h00);
    irq_is(1'b0);
    start(8'h0a, 16'h0002);
    pulse(0, 3);
    rd(`IDX_RUN_CONTROL, 8'h10);
    rd_count(16'h0002);
    irq_is(1'b1);
    wr(`IDX_IRQ_CLEAR, 8'h01);
    wr(`IDX_IRQ_ENABLE, 8'h00);
    start(8'h82, 16'h0100);
    pulse(2, 1);
    rd(`IDX_RUN_CONTROL, 8'h00);
    rd(`IDX_IRQ_STATUS, 8'h02);
    wr(`IDX_IRQ_CLEAR, 8'h03);
    start(8'h02, 16'h0100);
    pulse(2, 1);
    rd(`IDX_RUN_CONTROL, 8'h10);
    start(8'ha2, 16'h0100);
    pulse(2, 1);
    rd(`IDX_RUN_CONTROL, 8'h10);
    rd(`IDX_IRQ_STATUS, 8'h00);
    wr(`IDX_RUN_CONTROL, 8'h01);
    wr(`IDX_A_CONTROL, 8'h02);
    pulse(3, 1);
    rd(`IDX_RUN_CONTROL, 8'h00);
    wr(`IDX_A_CONTROL, 8'h12);
    pulse(3, 1);
    rd(`IDX_RUN_CONTROL, 8'h10);
    rd_count(16'h0100);
    wr(`IDX_RUN_CONTROL, 8'h01);
    wr(`IDX_A_CONTROL, 8'h22);
    pulse(4, 1);
    rd(`IDX_RUN_CONTROL, 8'h10);
    pulse(4, 1);
    rd(`IDX_RUN_CONTROL, 8'h00);
    wr(`IDX_A_RELOAD_HIGH, 8'h00);
    wr(`IDX_A_RELOAD_LOW, 8'h01);
    pulse(4, 1);
    pulse(0, 2);
    rd(`IDX_IRQ_STATUS, 8'h00);
    rd_count(16'h0000);
    wr(`IDX_RUN_CONTROL, 8'h01);
    wr(`IDX_A_CONTROL, 8'h32);
    pulse(4, 1);
    pulse(0, 2);
    rd(`IDX_IRQ_STATUS, 8'h01);
    wr(`IDX_RUN_CONTROL, 8'h01);
    wr(`IDX_IRQ_CLEAR, 8'h03);
    measure(8'h00, 1000, 8'h44);
    measure(8'h01, 9440, 8'h0a);
    report_and_stop();
  end
endmodule
